// *** hdl/cid_class_rom.sv ***
// class table: length kind of each instruction class, registered read
`include "cid_consts.svh"

module cid_class_rom (
   // clock
   input  wire logic       i_clk,
   // lookup
   input  wire logic [5:0] i_addr,
   output logic      [1:0] o_kind
);
   import cid_pkg::*;

   logic [1:0] kind_r;
   logic [1:0] kind_nxt;

   always_comb begin
      case (cid_class_t'(i_addr))
         CID_ADD, CID_ADDC, CID_SUB, CID_SUBC, CID_AND, CID_OR, CID_XOR, CID_CMP,
         CID_CMPDEC, CID_CMPINC, CID_MOV, CID_BYTEEXT, CID_EXTPAGE, CID_EXTSEG: begin
            kind_nxt = `CID_KIND_EITHER;
         end
         CID_BITCOPY, CID_BITLOGIC, CID_BITCMP, CID_BYTEFIELD, CID_JMPCOND, CID_JMPFAR,
         CID_BRHIGH, CID_BRLOW, CID_CALLCOND, CID_CALLFAR, CID_PUSHCALL, CID_CTXSW,
         CID_SWRESET, CID_IDLE, CID_PWRDOWN, CID_WDSERVE, CID_WDCTL, CID_INITEND: begin
            kind_nxt = `CID_KIND_FOUR;
         end
         CID_MUL, CID_DIV, CID_DIVL, CID_CPL, CID_NEG, CID_BITSET, CID_NORMCNT, CID_SHIFT,
         CID_ROTATE, CID_SIGNSHR, CID_VECCALL, CID_PUSHPOP, CID_RETNEAR, CID_RETFAR,
         CID_RETINT, CID_SWBREAK, CID_ATOMIC, CID_EXTREG, CID_NOP: begin
            kind_nxt = `CID_KIND_TWO;
         end
         default: begin
            kind_nxt = `CID_KIND_BAD;
         end
      endcase
   end

   always_ff @(posedge i_clk) begin
      kind_r <= kind_nxt;
   end

   assign o_kind = kind_r;

endmodule

// *** hdl/cid_consts.svh ***
// constants for the instruction class decoder
// What this block does
// - add and subtract, word or byte, optional carry, 2 or 4 bytes long
// - signed or unsigned 16 by 16 register multiply, 2 bytes
// - signed or unsigned 16 by 16 divide of low product word, 2 bytes
// - signed or unsigned 32 by 16 long divide of product pair, 2 bytes
// - compare word to register then decrement register by 1 or 2
// - compare word to register then increment register by 1 or 2
// - normalize count of a word register stored to a register, 2 bytes
// - arithmetic right shift fills with sign bit, 2 bytes
// - byte to word move with sign or zero extension, 2 or 4 bytes
// - masked modify of high or low byte of bit word, 4 bytes
// - copy one bit to another, optionally inverted, 4 bytes
// - branch if bit set, variant also clears it, 4 bytes
// - branch if bit clear, variant also sets it, 4 bytes
// - far jump to any code segment, 4 bytes
// - far call to any code segment, 4 bytes
// - push register then call absolute, 4 bytes
// - push register then load it with word operand, 4 bytes
// - near return, variant also pops a register, 2 bytes
// - software vector call by immediate number, 2 bytes
// - extended register prefix starts a sequence, 2 bytes
// - extended page prefix, optional register redirect, 2 or 4 bytes
// - extended segment prefix, optional register redirect, 2 or 4 bytes
// - power down decodes as legal 4 byte instruction, does nothing
`ifndef CID_CONSTS_SVH
`define CID_CONSTS_SVH

// opcode byte layout: class index, variant, long form
`define CID_OPC_CLASS_HI  7
`define CID_OPC_CLASS_LO  2
`define CID_OPC_VARIANT   1
`define CID_OPC_LONG      0
`define CID_NUM_CLASSES   6'h33

// length kinds held in the class table
`define CID_KIND_BAD      2'h0
`define CID_KIND_TWO      2'h1
`define CID_KIND_FOUR     2'h2
`define CID_KIND_EITHER   2'h3

// byte lengths
`define CID_LEN_TWO       3'h2
`define CID_LEN_FOUR      3'h4

// instruction pointer after reset
`define CID_IP_RESET      24'h000000

`endif

// *** hdl/cid_decoder.sv ***
// instruction class decoder with instruction pointer
`include "cid_consts.svh"

module cid_decoder (
   // clock and reset
   input  wire logic                i_clk,
   input  wire logic                i_rst,
   // fetch side
   input  wire logic                i_fetch_valid,
   input  wire logic [31:0]         i_fetch_word,
   output logic                     o_fetch_ready,
   output logic [23:0]              o_fetch_ip,
   // pointer load from execution
   input  wire logic                i_ip_load,
   input  wire logic [23:0]         i_ip_value,
   // decoded instruction
   output logic                     o_dec_valid,
   input  wire logic                i_exec_ready,
   output logic [31:0]              o_dec_word,
   output logic [23:0]              o_dec_ip,
   output cid_pkg::cid_class_t      o_dec_class,
   output logic [2:0]               o_dec_len,
   output logic                     o_illegal,
   // operation flags
   output logic                     o_byte_op,
   output logic                     o_with_carry,
   output logic                     o_unsigned_op,
   output logic                     o_long_div,
   output logic                     o_step_two,
   output logic                     o_step_down,
   output logic                     o_zero_ext,
   output logic                     o_arith_shift,
   output logic                     o_bit_invert,
   output logic                     o_bit_modify,
   output logic                     o_branch_on_set,
   output logic                     o_high_byte,
   output logic                     o_push,
   output logic                     o_pop,
   output logic                     o_call,
   output logic                     o_far,
   output logic                     o_seq_prefix,
   output logic                     o_seq_reg,
   output logic                     o_no_action
);
   import cid_pkg::*;

   cid_state_t s_r;
   cid_state_t s_nxt;
   logic [1:0] kind;
   logic [5:0] cls_idx;
   logic       var_bit;
   logic       long_bit;
   cid_class_t c;

   assign cls_idx  = s_r.word[`CID_OPC_CLASS_HI:`CID_OPC_CLASS_LO];
   assign var_bit  = s_r.word[`CID_OPC_VARIANT];
   assign long_bit = s_r.word[`CID_OPC_LONG];

   // length kind of the class index read from the table in the cycle after capture
   cid_class_rom u_rom (
      .i_clk  (i_clk),
      .i_addr (cls_idx),
      .o_kind (kind)
   );

   always_comb begin
      c = (cls_idx < `CID_NUM_CLASSES) ? cid_class_t'(cls_idx) : CID_NOP;
   end

   always_comb begin
      s_nxt = s_r;
      unique case (s_r.st)
         CID_ST_IDLE: begin
            if (i_fetch_valid) begin
               s_nxt.word = i_fetch_word;
               s_nxt.dip  = s_r.ip;
               s_nxt.st   = CID_ST_LOOK;
            end
         end
         CID_ST_LOOK: begin
            s_nxt.st = CID_ST_DEC;
         end
         CID_ST_DEC: begin
            s_nxt.st  = CID_ST_HOLD;
            s_nxt.cls = c;
            // length from the class table and the long form bit
            unique case (kind)
               `CID_KIND_EITHER: begin
                  s_nxt.len     = long_bit ? `CID_LEN_FOUR : `CID_LEN_TWO;
                  s_nxt.illegal = 1'b0;
               end
               `CID_KIND_FOUR: begin
                  s_nxt.len     = `CID_LEN_FOUR;
                  s_nxt.illegal = !long_bit;
               end
               `CID_KIND_TWO: begin
                  s_nxt.len     = `CID_LEN_TWO;
                  s_nxt.illegal = long_bit;
               end
               `CID_KIND_BAD: begin
                  s_nxt.len     = `CID_LEN_TWO;
                  s_nxt.illegal = 1'b1;
               end
            endcase
            s_nxt.byte_op       = var_bit && (c inside {CID_ADD, CID_ADDC, CID_SUB, CID_SUBC,
                                  CID_AND, CID_OR, CID_XOR, CID_CMP, CID_MOV, CID_CPL, CID_NEG});
            s_nxt.with_carry    = c inside {CID_ADDC, CID_SUBC};
            s_nxt.unsigned_op   = var_bit && (c inside {CID_MUL, CID_DIV, CID_DIVL});
            s_nxt.long_div      = (c == CID_DIVL);
            s_nxt.step_two      = var_bit && (c inside {CID_CMPDEC, CID_CMPINC});
            s_nxt.step_down     = (c == CID_CMPDEC);
            s_nxt.zero_ext      = var_bit && (c == CID_BYTEEXT);
            s_nxt.arith_shift   = (c == CID_SIGNSHR);
            s_nxt.bit_invert    = var_bit && (c == CID_BITCOPY);
            s_nxt.bit_modify    = var_bit && (c inside {CID_BRHIGH, CID_BRLOW});
            s_nxt.branch_on_set = (c == CID_BRHIGH);
            s_nxt.high_byte     = var_bit && (c == CID_BYTEFIELD);
            s_nxt.push          = (c inside {CID_PUSHCALL, CID_CTXSW, CID_VECCALL}) ||
                                  (c == CID_PUSHPOP && !var_bit);
            s_nxt.pop           = var_bit && (c inside {CID_RETNEAR, CID_PUSHPOP});
            s_nxt.call          = c inside {CID_CALLCOND, CID_CALLFAR, CID_PUSHCALL, CID_VECCALL};
            s_nxt.far           = c inside {CID_JMPFAR, CID_CALLFAR};
            s_nxt.seq_prefix    = c inside {CID_EXTREG, CID_EXTPAGE, CID_EXTSEG, CID_ATOMIC};
            s_nxt.seq_reg       = (c == CID_EXTREG) ||
                                  (var_bit && (c inside {CID_EXTPAGE, CID_EXTSEG}));
            // power down in its four byte form is legal but does nothing
            s_nxt.no_action     = (c == CID_PWRDOWN);
         end
         CID_ST_HOLD: begin
            if (i_exec_ready) begin
               s_nxt.ip = s_r.ip + {21'h000000, s_r.len};
               s_nxt.st = CID_ST_IDLE;
            end
         end
      endcase
      // a pointer load flushes any pending decode
      if (i_ip_load) begin
         s_nxt.ip = i_ip_value;
         s_nxt.st = CID_ST_IDLE;
      end
      if (i_rst) begin
         s_nxt               = '0;
         s_nxt.st            = CID_ST_IDLE;
         s_nxt.cls           = CID_NOP;
         s_nxt.ip            = `CID_IP_RESET;
         s_nxt.dip           = `CID_IP_RESET;
         s_nxt.len           = `CID_LEN_TWO;
      end
   end

   always_ff @(posedge i_clk) begin
      s_r <= s_nxt;
   end

   assign o_fetch_ready   = (s_r.st == CID_ST_IDLE) && !i_ip_load;
   assign o_fetch_ip      = s_r.ip;
   assign o_dec_valid     = (s_r.st == CID_ST_HOLD);
   assign o_dec_word      = s_r.word;
   assign o_dec_ip        = s_r.dip;
   assign o_dec_class     = s_r.cls;
   assign o_dec_len       = s_r.len;
   assign o_illegal       = s_r.illegal;
   assign o_byte_op       = s_r.byte_op;
   assign o_with_carry    = s_r.with_carry;
   assign o_unsigned_op   = s_r.unsigned_op;
   assign o_long_div      = s_r.long_div;
   assign o_step_two      = s_r.step_two;
   assign o_step_down     = s_r.step_down;
   assign o_zero_ext      = s_r.zero_ext;
   assign o_arith_shift   = s_r.arith_shift;
   assign o_bit_invert    = s_r.bit_invert;
   assign o_bit_modify    = s_r.bit_modify;
   assign o_branch_on_set = s_r.branch_on_set;
   assign o_high_byte     = s_r.high_byte;
   assign o_push          = s_r.push;
   assign o_pop           = s_r.pop;
   assign o_call          = s_r.call;
   assign o_far           = s_r.far;
   assign o_seq_prefix    = s_r.seq_prefix;
   assign o_seq_reg       = s_r.seq_reg;
   assign o_no_action     = s_r.no_action;

   a_add_len_form: assert property (@(posedge i_clk) disable iff (i_rst)
      (o_dec_valid && o_dec_class == CID_ADD) |-> (o_dec_len == (o_dec_word[0] ? 3'h4 : 3'h2)) && !o_illegal)
      else $error("add length does not follow long form bit");

   a_mul_two_bytes: assert property (@(posedge i_clk) disable iff (i_rst)
      (o_dec_valid && o_dec_class == CID_MUL && !o_illegal) |-> (o_dec_len == 3'h2)
      && (o_unsigned_op == o_dec_word[1]))
      else $error("multiply length or sign flag wrong");

   a_divl_flags: assert property (@(posedge i_clk) disable iff (i_rst)
      (o_dec_valid && o_dec_class == CID_DIVL) |-> o_long_div && (o_dec_len == 3'h2))
      else $error("long divide not flagged");

   a_cmp_dec_step: assert property (@(posedge i_clk) disable iff (i_rst)
      (o_dec_valid && o_dec_class == CID_CMPDEC) |-> o_step_down && (o_step_two == o_dec_word[1]))
      else $error("compare decrement step wrong");

   a_br_high_mod: assert property (@(posedge i_clk) disable iff (i_rst)
      (o_dec_valid && o_dec_class == CID_BRHIGH) |-> o_branch_on_set && (o_bit_modify == o_dec_word[1])
      && (o_dec_len == 3'h4))
      else $error("bit set branch flags wrong");

   a_br_low_mod: assert property (@(posedge i_clk) disable iff (i_rst)
      (o_dec_valid && o_dec_class == CID_BRLOW) |-> !o_branch_on_set && (o_bit_modify == o_dec_word[1]))
      else $error("bit clear branch flags wrong");

   a_ext_reg_pfx: assert property (@(posedge i_clk) disable iff (i_rst)
      (o_dec_valid && o_dec_class == CID_EXTREG) |-> o_seq_prefix && o_seq_reg && (o_dec_len == 3'h2))
      else $error("register prefix not flagged");

   a_pwr_no_action: assert property (@(posedge i_clk) disable iff (i_rst)
      (o_dec_valid && o_dec_class == CID_PWRDOWN && o_dec_word[0]) |-> o_no_action && !o_illegal
      && (o_dec_len == 3'h4))
      else $error("power down not decoded as legal no-op");

   a_ip_advance: assert property (@(posedge i_clk) disable iff (i_rst)
      (o_dec_valid && i_exec_ready && !i_ip_load) |=> (o_fetch_ip == $past(o_fetch_ip) + {21'h000000, $past(o_dec_len)}))
      else $error("pointer did not advance by length");

   a_decode_latency: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_fetch_valid && o_fetch_ready) ##1 !i_ip_load ##1 !i_ip_load |=> o_dec_valid)
      else $error("decode not ready three cycles after fetch");

   a_carry_flag: assert property (@(posedge i_clk) disable iff (i_rst)
      o_dec_valid |-> (o_with_carry == (o_dec_class inside {CID_ADDC, CID_SUBC})))
      else $error("carry flag wrong");

   a_div_flags: assert property (@(posedge i_clk) disable iff (i_rst)
      (o_dec_valid && o_dec_class == CID_DIV) |-> (o_unsigned_op == o_dec_word[1])
      && !o_long_div && (o_dec_len == 3'h2))
      else $error("divide flags wrong");

   a_cmp_inc_step: assert property (@(posedge i_clk) disable iff (i_rst)
      (o_dec_valid && o_dec_class == CID_CMPINC) |-> !o_step_down && (o_step_two == o_dec_word[1])
      && (o_dec_len == (o_dec_word[0] ? 3'h4 : 3'h2)))
      else $error("compare increment step wrong");

   a_norm_len: assert property (@(posedge i_clk) disable iff (i_rst)
      (o_dec_valid && o_dec_class == CID_NORMCNT) |-> (o_dec_len == 3'h2) && (o_illegal == o_dec_word[0]))
      else $error("normalize count length wrong");

   a_shift_flag: assert property (@(posedge i_clk) disable iff (i_rst)
      o_dec_valid |-> (o_arith_shift == (o_dec_class == CID_SIGNSHR)))
      else $error("sign shift flag wrong");

   a_byte_ext: assert property (@(posedge i_clk) disable iff (i_rst)
      (o_dec_valid && o_dec_class == CID_BYTEEXT) |-> (o_zero_ext == o_dec_word[1]) && !o_illegal
      && (o_dec_len == (o_dec_word[0] ? 3'h4 : 3'h2)))
      else $error("byte extend flags wrong");

   a_field_byte: assert property (@(posedge i_clk) disable iff (i_rst)
      (o_dec_valid && o_dec_class == CID_BYTEFIELD) |-> (o_high_byte == o_dec_word[1]) && (o_dec_len == 3'h4))
      else $error("byte field flags wrong");

   a_bit_copy: assert property (@(posedge i_clk) disable iff (i_rst)
      (o_dec_valid && o_dec_class == CID_BITCOPY) |-> (o_bit_invert == o_dec_word[1]) && (o_dec_len == 3'h4))
      else $error("bit copy flags wrong");

   a_far_jump: assert property (@(posedge i_clk) disable iff (i_rst)
      (o_dec_valid && o_dec_class == CID_JMPFAR) |-> o_far && !o_call && (o_dec_len == 3'h4))
      else $error("far jump flags wrong");

   a_far_call: assert property (@(posedge i_clk) disable iff (i_rst)
      (o_dec_valid && o_dec_class == CID_CALLFAR) |-> o_far && o_call && (o_dec_len == 3'h4))
      else $error("far call flags wrong");

   a_push_call: assert property (@(posedge i_clk) disable iff (i_rst)
      (o_dec_valid && o_dec_class == CID_PUSHCALL) |-> o_push && o_call && !o_pop && (o_dec_len == 3'h4))
      else $error("push call flags wrong");

   a_ctx_switch: assert property (@(posedge i_clk) disable iff (i_rst)
      (o_dec_valid && o_dec_class == CID_CTXSW) |-> o_push && !o_call && !o_pop && (o_dec_len == 3'h4))
      else $error("context switch flags wrong");

   a_ret_pop: assert property (@(posedge i_clk) disable iff (i_rst)
      (o_dec_valid && o_dec_class == CID_RETNEAR) |-> (o_pop == o_dec_word[1]) && !o_push && (o_dec_len == 3'h2))
      else $error("near return flags wrong");

   a_vec_call: assert property (@(posedge i_clk) disable iff (i_rst)
      (o_dec_valid && o_dec_class == CID_VECCALL) |-> o_call && !o_far && (o_dec_len == 3'h2))
      else $error("vector call flags wrong");

   a_ext_page: assert property (@(posedge i_clk) disable iff (i_rst)
      (o_dec_valid && o_dec_class == CID_EXTPAGE) |-> o_seq_prefix && (o_seq_reg == o_dec_word[1])
      && (o_dec_len == (o_dec_word[0] ? 3'h4 : 3'h2)))
      else $error("page prefix flags wrong");

   a_ext_seg: assert property (@(posedge i_clk) disable iff (i_rst)
      (o_dec_valid && o_dec_class == CID_EXTSEG) |-> o_seq_prefix && (o_seq_reg == o_dec_word[1])
      && (o_dec_len == (o_dec_word[0] ? 3'h4 : 3'h2)))
      else $error("segment prefix flags wrong");

   a_unknown_bad: assert property (@(posedge i_clk) disable iff (i_rst)
      (o_dec_valid && o_dec_word[`CID_OPC_CLASS_HI:`CID_OPC_CLASS_LO] >= `CID_NUM_CLASSES)
      |-> o_illegal && (o_dec_class == CID_NOP) && (o_dec_len == 3'h2))
      else $error("unknown class not flagged illegal");

   a_hold_stable: assert property (@(posedge i_clk) disable iff (i_rst)
      (o_dec_valid && !i_exec_ready && !i_ip_load) |=> o_dec_valid && $stable(o_dec_word)
      && $stable(o_dec_len))
      else $error("decode did not stand until taken");

   a_fetch_refused: assert property (@(posedge i_clk) disable iff (i_rst)
      o_dec_valid |-> !o_fetch_ready)
      else $error("fetch ready while decode pending");

   a_load_ip: assert property (@(posedge i_clk) disable iff (i_rst)
      i_ip_load |=> (o_fetch_ip == $past(i_ip_value)) && !o_dec_valid)
      else $error("pointer load not applied");

endmodule

// *** hdl/cid_pkg.sv ***
// types of the instruction class decoder
package cid_pkg;

   typedef enum logic [5:0] {
      CID_ADD, CID_ADDC, CID_SUB, CID_SUBC, CID_MUL, CID_DIV, CID_DIVL, CID_CPL,
      CID_NEG, CID_AND, CID_OR, CID_XOR, CID_BITSET, CID_BITCOPY, CID_BITLOGIC, CID_BITCMP,
      CID_BYTEFIELD, CID_CMP, CID_CMPDEC, CID_CMPINC, CID_NORMCNT, CID_SHIFT, CID_ROTATE,
      CID_SIGNSHR, CID_MOV, CID_BYTEEXT, CID_JMPCOND, CID_JMPFAR, CID_BRHIGH, CID_BRLOW,
      CID_CALLCOND, CID_CALLFAR, CID_PUSHCALL, CID_VECCALL, CID_PUSHPOP, CID_CTXSW,
      CID_RETNEAR, CID_RETFAR, CID_RETINT, CID_SWBREAK, CID_SWRESET, CID_IDLE, CID_PWRDOWN,
      CID_WDSERVE, CID_WDCTL, CID_INITEND, CID_ATOMIC, CID_EXTREG, CID_EXTPAGE, CID_EXTSEG,
      CID_NOP
   } cid_class_t;

   typedef enum logic [1:0] {
      CID_ST_IDLE,
      CID_ST_LOOK,
      CID_ST_DEC,
      CID_ST_HOLD
   } cid_st_t;

   typedef struct packed {
      cid_st_t     st;
      logic [31:0] word;
      logic [23:0] ip;
      logic [23:0] dip;
      cid_class_t  cls;
      logic [2:0]  len;
      logic        illegal;
      logic        byte_op;
      logic        with_carry;
      logic        unsigned_op;
      logic        long_div;
      logic        step_two;
      logic        step_down;
      logic        zero_ext;
      logic        arith_shift;
      logic        bit_invert;
      logic        bit_modify;
      logic        branch_on_set;
      logic        high_byte;
      logic        push;
      logic        pop;
      logic        call;
      logic        far;
      logic        seq_prefix;
      logic        seq_reg;
      logic        no_action;
   } cid_state_t;

endpackage

// *** verification/cid_decoder_tb.sv ***
// self-checking bench of the instruction class decoder
module cid_decoder_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import cid_pkg::*;

   logic i_clk = 1'b0, i_rst = 1'b1, i_fetch_valid = 1'b0, i_ip_load = 1'b0;
   logic [31:0] i_fetch_word = 32'h0;
   logic [23:0] i_ip_value = 24'h0;
   logic [2:0] delay = 3'h0;
   logic i_exec_ready, o_fetch_ready, o_dec_valid, o_illegal;
   logic [23:0] o_fetch_ip, o_dec_ip, exp_ip;
   logic [31:0] o_dec_word;
   logic [2:0] o_dec_len;
   cid_class_t o_dec_class;
   wire logic [18:0] flags;
   int err_count = 0;
   int checks = 0;

   always #5 i_clk = ~i_clk;

   cid_exec_model u_exec (.i_clk(i_clk), .i_rst(i_rst), .i_dec_valid(o_dec_valid), .i_delay(delay),
      .o_exec_ready(i_exec_ready));

   cid_decoder DUT (.i_clk(i_clk), .i_rst(i_rst), .i_fetch_valid(i_fetch_valid), .i_fetch_word(i_fetch_word),
      .o_fetch_ready(o_fetch_ready), .o_fetch_ip(o_fetch_ip), .i_ip_load(i_ip_load), .i_ip_value(i_ip_value),
      .o_dec_valid(o_dec_valid), .i_exec_ready(i_exec_ready), .o_dec_word(o_dec_word), .o_dec_ip(o_dec_ip),
      .o_dec_class(o_dec_class), .o_dec_len(o_dec_len), .o_illegal(o_illegal), .o_byte_op(flags[18]),
      .o_with_carry(flags[17]), .o_unsigned_op(flags[16]), .o_long_div(flags[15]), .o_step_two(flags[14]),
      .o_step_down(flags[13]), .o_zero_ext(flags[12]), .o_arith_shift(flags[11]), .o_bit_invert(flags[10]),
      .o_bit_modify(flags[9]), .o_branch_on_set(flags[8]), .o_high_byte(flags[7]), .o_push(flags[6]),
      .o_pop(flags[5]), .o_call(flags[4]), .o_far(flags[3]), .o_seq_prefix(flags[2]), .o_seq_reg(flags[1]),
      .o_no_action(flags[0]));

   task automatic check_vec(input logic [31:0] act, input logic [31:0] exp, input string what);
      checks++;
      if (act !== exp) begin
         err_count++;
         $display("MISMATCH at %0t: %s got %h expected %h", $time, what, act, exp);
      end
   endtask

   // 0 two bytes, 1 four bytes, 2 either
   function automatic logic [1:0] kind(input cid_class_t c);
      if (c inside {CID_ADD, CID_ADDC, CID_SUB, CID_SUBC, CID_AND, CID_OR, CID_XOR, CID_CMP, CID_CMPDEC,
                    CID_CMPINC, CID_MOV, CID_BYTEEXT, CID_EXTPAGE, CID_EXTSEG}) return 2'h2;
      if (c inside {CID_BITCOPY, CID_BITLOGIC, CID_BITCMP, CID_BYTEFIELD, CID_JMPCOND, CID_JMPFAR, CID_BRHIGH,
                    CID_BRLOW, CID_CALLCOND, CID_CALLFAR, CID_PUSHCALL, CID_CTXSW, CID_SWRESET, CID_IDLE,
                    CID_PWRDOWN, CID_WDSERVE, CID_WDCTL, CID_INITEND}) return 2'h1;
      return 2'h0;
   endfunction

   function automatic logic [18:0] exp_flags(input cid_class_t c, input logic v);
      logic [18:0] f;
      f[18] = v && (c inside {CID_ADD, CID_ADDC, CID_SUB, CID_SUBC, CID_AND, CID_OR, CID_XOR, CID_CMP,
                              CID_MOV, CID_CPL, CID_NEG});
      f[17] = c inside {CID_ADDC, CID_SUBC};
      f[16] = v && (c inside {CID_MUL, CID_DIV, CID_DIVL});
      f[15] = c == CID_DIVL;
      f[14] = v && (c inside {CID_CMPDEC, CID_CMPINC});
      f[13] = c == CID_CMPDEC;
      f[12] = v && c == CID_BYTEEXT;
      f[11] = c == CID_SIGNSHR;
      f[10] = v && c == CID_BITCOPY;
      f[9]  = v && (c inside {CID_BRHIGH, CID_BRLOW});
      f[8]  = c == CID_BRHIGH;
      f[7]  = v && c == CID_BYTEFIELD;
      f[6]  = (c inside {CID_PUSHCALL, CID_CTXSW, CID_VECCALL}) || (!v && c == CID_PUSHPOP);
      f[5]  = v && (c inside {CID_RETNEAR, CID_PUSHPOP});
      f[4]  = c inside {CID_CALLCOND, CID_CALLFAR, CID_PUSHCALL, CID_VECCALL};
      f[3]  = c inside {CID_JMPFAR, CID_CALLFAR};
      f[2]  = c inside {CID_EXTREG, CID_EXTPAGE, CID_EXTSEG, CID_ATOMIC};
      f[1]  = c == CID_EXTREG || (v && (c inside {CID_EXTPAGE, CID_EXTSEG}));
      f[0]  = c == CID_PWRDOWN;
      return f;
   endfunction

   // offer one word, wait until taken, leave the edge that took it just passed
   task automatic offer(input logic [31:0] w);
      int n;
      @(posedge i_clk);
      i_fetch_valid <= 1'b1;
      i_fetch_word  <= w;
      n = 0;
      do begin
         @(negedge i_clk);
         n++;
      end while (o_fetch_ready !== 1'b1 && n < 20);
      @(posedge i_clk);
      i_fetch_valid <= 1'b0;
   endtask

   task automatic run_one(input logic [5:0] idx, input logic v, input logic l);
      logic [31:0] w;
      cid_class_t c;
      logic [1:0] k;
      logic [2:0] len;
      logic bad;
      int n;
      w = {idx, 2'h1, ~idx, 2'h2, 8'hc3, idx, v, l};
      c = cid_class_t'(idx);
      k = kind(c);
      len = (k == 2'h2) ? (l ? 3'h4 : 3'h2) : (k == 2'h1 ? 3'h4 : 3'h2);
      bad = idx >= 6'h33 || (k == 2'h0 && l) || (k == 2'h1 && !l);
      offer(w);
      repeat (3) @(posedge i_clk);
      @(negedge i_clk);
      check_vec(o_dec_valid, 1, "dec valid");
      check_vec(o_fetch_ready, 0, "fetch refused while pending");
      check_vec(o_dec_word, w, "dec word");
      check_vec(o_dec_ip, exp_ip, "dec ip");
      check_vec(o_illegal, bad, "illegal");
      if (idx < 6'h33) begin
         check_vec(o_dec_class, c, "class");
         check_vec(o_dec_len, len, "length");
      end else begin
         check_vec(o_dec_class, CID_NOP, "class of unknown index");
         check_vec(o_dec_len, 3'h2, "length of unknown index");
      end
      if (!bad) check_vec(flags, exp_flags(c, v), "flags");
      n = 0;
      while (o_dec_valid !== 1'b0 && n < 20) begin
         @(negedge i_clk);
         n++;
      end
      exp_ip = exp_ip + len;
      check_vec(o_dec_valid, 0, "decode taken");
      check_vec(o_fetch_ip, exp_ip, "pointer advance");
   endtask

   // every class, variant and length bit, exec side alternating prompt and slow
   task automatic test_all_classes;
      for (int i = 0; i < 53; i++) begin
         for (int j = 0; j < 4; j++) begin
            delay <= 3'((i + j) % 2 * 3);
            run_one(6'(i), j[1], j[0]);
         end
      end
      $display("test all classes done");
   endtask

   // pointer load flushes a pending decode and refuses fetch while high
   task automatic test_ip_load;
      offer({24'h0, 8'h00});
      @(posedge i_clk);
      i_ip_load  <= 1'b1;
      i_ip_value <= 24'h12345a;
      repeat (2) @(negedge i_clk);
      check_vec(o_fetch_ready, 0, "fetch refused during load");
      @(posedge i_clk);
      i_ip_load <= 1'b0;
      repeat (4) @(negedge i_clk);
      check_vec(o_dec_valid, 0, "decode flushed");
      check_vec(o_fetch_ip, 24'h12345a, "loaded pointer");
      exp_ip = 24'h12345a;
      run_one(6'h2a, 1'b0, 1'b1);
      $display("test ip load done");
   endtask

   // reset in mid decode returns pointer and outputs to reset values
   task automatic test_reset;
      offer({24'h0, 8'h04});
      @(posedge i_clk);
      i_rst <= 1'b1;
      @(posedge i_clk);
      i_rst <= 1'b0;
      @(negedge i_clk);
      check_vec(o_dec_valid, 0, "valid after reset");
      check_vec(o_fetch_ready, 1, "ready after reset");
      check_vec(o_fetch_ip, 24'h0, "pointer after reset");
      check_vec(o_dec_len, 3'h2, "length after reset");
      check_vec(o_dec_class, CID_NOP, "class after reset");
      check_vec(flags, 19'h0, "flags after reset");
      exp_ip = 24'h0;
      run_one(6'h03, 1'b1, 1'b0);
      $display("test reset done");
   endtask

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   initial begin
      #200000;
      err_count++;
      $display("MISMATCH at %0t: watchdog expired", $time);
      wrap_up();
   end

   initial begin
      exp_ip = 24'h0;
      repeat (16) @(posedge i_clk);
      i_rst <= 1'b0;
      test_all_classes();
      test_ip_load();
      test_reset();
      wrap_up();
   end
endmodule

// *** verification/cid_exec_model.sv ***
// execution side model: takes each decode after a chosen number of cycles
module cid_exec_model (
   // clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   // decode handshake
   input  wire logic       i_dec_valid,
   input  wire logic [2:0] i_delay,
   output logic            o_exec_ready
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [2:0] cnt_r;

   // one cycle pulse, dropped at the accepting edge so one decode is taken once
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         cnt_r        <= 3'h0;
         o_exec_ready <= 1'b0;
      end else if (o_exec_ready) begin
         cnt_r        <= 3'h0;
         o_exec_ready <= 1'b0;
      end else if (i_dec_valid) begin
         if (cnt_r == i_delay) begin
            o_exec_ready <= 1'b1;
         end else begin
            cnt_r <= cnt_r + 3'h1;
         end
      end
   end
endmodule
